/* File: design/sspf_framer.sv */
`timescale 1ns/1ps
`default_nettype none
module sspf_framer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic serial_select_n,
	input wire logic serial_clock_line,
	input wire logic serial_in_line,
	output logic serial_out_line,
	output logic serial_out_oe,
	output logic cmd_valid,
	output sspf_pkg::sspf_cmd_t cmd,
	output logic cmd_abort,
	output logic tx_req,
	input wire logic [sspf_pkg::BYTE_W-1:0] tx_data
);
	import sspf_pkg::*;

	sspf_pins_t pins_raw;
	sspf_pins_t pins;
	sspf_state_t st;
	sspf_state_t next_st;
	logic rise;
	logic fall;
	logic [BYTE_W-1:0] rx_byte;
	logic [BYTE_W-1:0] load_byte;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	assign pins_raw = '{cs_n: serial_select_n, sck: serial_clock_line, sdi: serial_in_line};

	sspf_sync #(
		.WIDTH($bits(sspf_pins_t)),
		.RESET_VAL(PINS_IDLE)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	////////////////////////////////////////////////////////////////////////
	// framing and shifting
	// no free-running timebase: all progress waits on serial clock edges
	assign rise = pins.sck & ~st.sck_prev;
	assign fall = ~pins.sck & st.sck_prev;
	assign rx_byte = {st.rx_shift[MSB-1:0], pins.sdi};
	// dummy until the first instruction is complete, then caller data
	assign load_byte = st.issued ? tx_data : DUMMY_BYTE;

	always_comb begin
		next_st = st;
		next_st.sck_prev = pins.sck;
		next_st.cmd_valid = 1'b0;
		next_st.cmd_abort = 1'b0;
		next_st.tx_req = 1'b0;
		if (pins.cs_n) begin
			// select high clears framing; next select starts on an instruction
			next_st.bit_cnt = BIT_CNT_ZERO;
			next_st.rx_shift = RESET_BYTE;
			next_st.slot = SLOT_INSTR;
			next_st.issued = 1'b0;
			next_st.running = 1'b0;
			next_st.tx_shift = DUMMY_BYTE;
		end else begin
			if (rise) begin
				// sample on rising edge, msb first
				next_st.rx_shift = rx_byte;
				next_st.bit_cnt = BIT_CNT_W'(st.bit_cnt + BIT_CNT_ONE);
				if (st.bit_cnt == BIT_CNT_LAST) begin
					case (st.slot)
						SLOT_INSTR: begin
							if (rx_byte == NO_INSTR_BYTE) begin
								// zero byte: readout carries on, next byte is an instruction
								next_st.slot = SLOT_INSTR;
							end else begin
								next_st.instr_byte = rx_byte;
								next_st.slot = SLOT_PARAM;
								next_st.cmd_abort = st.running;
								next_st.running = 1'b0;
							end
						end
						SLOT_PARAM: begin
							next_st.cmd.code = st.instr_byte;
							next_st.cmd.param = rx_byte;
							next_st.cmd_valid = 1'b1;
							next_st.issued = 1'b1;
							next_st.running = 1'b1;
							next_st.slot = SLOT_INSTR;
						end
						default: begin
							next_st.slot = SLOT_INSTR;
						end
					endcase
				end
			end else if (fall) begin
				// output moves only after falling edge; load at byte boundary
				if (st.bit_cnt == BIT_CNT_ZERO) begin
					next_st.tx_shift = load_byte;
					next_st.tx_req = st.issued;
				end else begin
					next_st.tx_shift = {st.tx_shift[MSB-1:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		// rst_n low at any single core_clk edge resets; RST_MIN_CYC edges are not required
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign serial_out_line = st.tx_shift[MSB];
	// enable follows synchronised select, so release lags the pin by sync delay
	assign serial_out_oe = ~pins.cs_n;
	assign cmd_valid = st.cmd_valid;
	assign cmd = st.cmd;
	assign cmd_abort = st.cmd_abort;
	assign tx_req = st.tx_req;
endmodule : sspf_framer
`default_nettype wire

/* File: design/sspf_pkg.sv */
// Overview of operation
// - each instruction is instruction byte plus parameter
// - first byte after select low is instruction
// - instruction and parameter bytes alternate afterwards
// - unlimited back-to-back instructions under one select
// - transfer runs while select low, clock toggling
// - byte after zero byte is an instruction
// - new instruction aborts previous one
// - dummy out on first instruction, then data
// - output undriven while select high; the code releases the enable only after the two-stage sync delay on select
// - select high resets framing state
// - reset active low, 30 ns guaranteed
// - logic timing derives only from serial clock
// - sample on rising, change after falling
// - mode 0, msb first, below maximum clock
package sspf_pkg;
	localparam int BYTE_W = 8;
	localparam int BIT_CNT_W = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 3'h1;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
	localparam logic [BYTE_W-1:0] NO_INSTR_BYTE = 8'h00;
	localparam logic [BYTE_W-1:0] DUMMY_BYTE = 8'h00;
	localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
	localparam int MSB = BYTE_W - 1;
	// reset and clock timing
	localparam int CORE_CLK_MHZ = 250;
	localparam int RST_MIN_NS = 30;
	localparam int RST_MIN_CYC = (RST_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int SYNC_STAGES = 2;

	typedef enum logic {
		SLOT_INSTR,
		SLOT_PARAM
	} sspf_slot_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic sdi;
	} sspf_pins_t;

	// idle pin levels held by the synchronisers while in reset
	localparam sspf_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};

	typedef struct packed {
		logic [BYTE_W-1:0] code;
		logic [BYTE_W-1:0] param;
	} sspf_cmd_t;

	typedef struct packed {
		logic sck_prev;
		logic [BIT_CNT_W-1:0] bit_cnt;
		logic [BYTE_W-1:0] rx_shift;
		sspf_slot_t slot;
		logic [BYTE_W-1:0] instr_byte;
		logic issued;
		logic running;
		logic [BYTE_W-1:0] tx_shift;
		logic cmd_valid;
		logic cmd_abort;
		logic tx_req;
		sspf_cmd_t cmd;
	} sspf_state_t;
endpackage : sspf_pkg

/* File: design/sspf_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sspf_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import sspf_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sspf_sync_state_t;

	sspf_sync_state_t st;
	sspf_sync_state_t next_st;

	// stage1 is read only by stage2
	always_comb begin
		next_st = st;
		next_st.stage1 = async_in;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// idle levels: no false select or clock edge right after release
			st <= '{stage1: RESET_VAL, stage2: RESET_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stage2;
endmodule : sspf_sync
`default_nettype wire

/* File: dv/sspf_framer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sspf_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic serial_select_n,
	input wire logic serial_clock_line,
	input wire logic serial_out_line,
	input wire logic serial_out_oe,
	input wire logic cmd_valid,
	input wire sspf_pkg::sspf_cmd_t cmd,
	input wire logic cmd_abort,
	input wire logic tx_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// four cycles cover the two-flop select lag
	oe_off_a: assert property (serial_select_n [*4] |-> !serial_out_oe) else $error("oe on");
	oe_on_a: assert property (!serial_select_n [*4] |-> serial_out_oe) else $error("oe off");
	idle_quiet_a: assert property (serial_select_n [*4] |-> !(cmd_valid || cmd_abort || tx_req))
		else $error("idle pulse");
	valid_pulse_a: assert property (cmd_valid |-> serial_clock_line && !serial_select_n ##1 !cmd_valid)
		else $error("valid");
	abort_pulse_a: assert property (cmd_abort |-> serial_clock_line && !cmd_valid ##1 !cmd_abort)
		else $error("abort");
	tx_pulse_a: assert property (tx_req |-> !serial_clock_line ##1 !tx_req) else $error("txreq");
	cmd_hold_a: assert property (!cmd_valid |-> $stable(cmd)) else $error("cmd moved");
	out_edge_a: assert property (serial_out_oe && $changed(serial_out_line) |-> !serial_clock_line)
		else $error("out moved");
endmodule : sspf_chk
bind sspf_framer sspf_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
	.serial_select_n(serial_select_n), .serial_clock_line(serial_clock_line),
	.serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .cmd_valid(cmd_valid),
	.cmd(cmd), .cmd_abort(cmd_abort), .tx_req(tx_req));
`default_nettype wire

/* File: dv/sspf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sspf_host_model (
	input wire logic clk,
	input wire logic sdo,
	output logic cs_n,
	output logic sck,
	output logic sdi
);
	initial cs_n = 1'b1;
	initial sck = 1'b0;
	initial sdi = 1'b0;
	task automatic sel(input logic v);
		repeat (6) @(posedge clk);
		cs_n <= v;
		repeat (8) @(posedge clk);
	endtask : sel
	// six cycles a half period: slow enough for the synced edges
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		for (int i = 7; i > 7 - nb; i--) begin
			sdi <= tx[i];
			repeat (6) @(posedge clk);
			sck <= 1'b1;
			rx[i] = sdo;
			repeat (6) @(posedge clk);
			sck <= 1'b0;
		end
	endtask : xfer
	// stand-by: lines low before select; start-up raises select first
	task automatic standby(input logic down);
		if (down) begin
			sdi <= 1'b0;
			sck <= 1'b0;
			repeat (6) @(posedge clk);
			cs_n <= 1'b0;
		end else begin
			cs_n <= 1'b1;
			repeat (8) @(posedge clk);
		end
	endtask : standby
endmodule : sspf_host_model
`default_nettype wire

/* File: dv/tb_sensor_spi_instruction_framer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_spi_instruction_framer;
	import sspf_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, sck, sdi, out, oe, vld, abt, txr;
	logic [BYTE_W-1:0] txd = 8'h00;
	logic [BYTE_W-1:0] rx, p;
	sspf_cmd_t cmd;
	logic [BYTE_W-1:0] q[$];
	int n_fail = 0;
	int tests_run = 0;
	int n_vld = 0;
	int n_abt = 0;
	always #2 core_clk = ~core_clk;
	sspf_framer dut_u (.core_clk(core_clk), .rst_n(rst_n), .serial_select_n(cs_n),
		.serial_clock_line(sck), .serial_in_line(sdi), .serial_out_line(out),
		.serial_out_oe(oe), .cmd_valid(vld), .cmd(cmd), .cmd_abort(abt), .tx_req(txr),
		.tx_data(txd));
	sspf_host_model host_u (.clk(core_clk), .sdo(oe ? out : ~out), .cs_n(cs_n), .sck(sck),
		.sdi(sdi));
	always @(posedge core_clk) begin
		n_vld <= n_vld + int'(vld === 1'b1);
		n_abt <= n_abt + int'(abt === 1'b1);
		if (txr === 1'b1) begin
			q.push_back(txd);
			txd <= 8'($urandom);
		end
	end
	function automatic logic [7:0] nxt(input logic dummy);
		return dummy ? DUMMY_BYTE : q.pop_front();
	endfunction : nxt
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic b(input logic [7:0] v, input logic dummy);
		host_u.xfer(v, 8, rx);
		chk(16'(rx), 16'(nxt(dummy)));
	endtask : b
	task automatic wrap_up;
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		void'($urandom(32'h69F3));
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chk(16'(oe), 16'h0000);
		host_u.sel(1'b0);
		b(8'hA5, 1'b1);
		p = 8'($urandom);
		b(p, 1'b1);
		chk(cmd, {8'hA5, p});
		b(8'h00, 1'b0);
		b(8'h00, 1'b0);
		chk(16'(n_abt), 16'h0000);
		b(8'h5A, 1'b0);
		chk(16'(n_abt), 16'h0001);
		p = 8'($urandom);
		b(p, 1'b0);
		chk(cmd, {8'h5A, p});
		chk(16'(n_vld), 16'h0002);
		host_u.xfer(8'hFF, 4, rx);
		host_u.sel(1'b1);
		repeat (6) begin
			host_u.sel(1'b0);
			q.delete();
			p = 8'($urandom) | 8'h01;
			b(p, 1'b1);
			b(~p, 1'b1);
			chk(cmd, {p, ~p});
			host_u.sel(1'b1);
		end
		chk(16'(oe), 16'h0000);
		// stand-by and start-up with a minimum-length reset in mid-run
		host_u.standby(1'b1);
		rst_n <= 1'b0;
		repeat (RST_MIN_CYC) @(posedge core_clk);
		rst_n <= 1'b1;
		host_u.standby(1'b0);
		chk(16'(cmd), 16'h0000);
		chk(16'(oe), 16'h0000);
		q.delete();
		host_u.sel(1'b0);
		p = 8'($urandom);
		b(8'hC3, 1'b1);
		b(p, 1'b1);
		chk(cmd, {8'hC3, p});
		chk(16'(n_abt), 16'h0001);
		chk(16'(n_vld), 16'h0009);
		host_u.sel(1'b1);
		chk(16'(oe), 16'h0000);
		wrap_up();
	end
	initial begin
		#100000;
		n_fail++;
		wrap_up();
	end
endmodule : tb_sensor_spi_instruction_framer
`default_nettype wire
